/* design/mnt_defines.svh */
// constants for the main tuning word update block
// Function
// - sideband bit 1 selects lower sideband
// - follow bit 0: channels use own requests
// - follow bit 1 (reset): channels follow main
// - mode 000: byte writes raise no request
// - modes 001..110 request after given byte
// - reference load waits next reference rising edge
// - any trigger also loads calibration tone word
// - ack reads 1 once words loaded
// - request 0 clears ack, 0-to-1 loads
// - plain mode: f = fclk*word/2^48
// - fractional mode adds numerator/denominator fraction
// - all controls banked per converter page
// - low bytes at 0x114..0x116, reset zero
// - fractional enable selects modulus accumulation, reset off
// - phase offset 16-bit two's complement, 180 full
`ifndef MNT_DEFINES_SVH
`define MNT_DEFINES_SVH
`define MNT_ADDR_CFG     12'h112
`define MNT_ADDR_UPD     12'h113
`define MNT_ADDR_FTW0    12'h114
`define MNT_ADDR_FTW1    12'h115
`define MNT_ADDR_FTW2    12'h116
`define MNT_ADDR_FTW3    12'h117
`define MNT_ADDR_FTW4    12'h118
`define MNT_ADDR_FTW5    12'h119
`define MNT_ADDR_PH0     12'h11c
`define MNT_ADDR_PH1     12'h11d
`define MNT_ADDR_MOD0    12'h124
`define MNT_ADDR_DLT0    12'h12a
`define MNT_ADDR_PAGE    12'h008
`define MNT_CFG_RESET    8'h01
`define MNT_UPD_RESET    8'h00
`define MNT_BIT_FOLLOW   0
`define MNT_BIT_SIDEBAND 1
`define MNT_BIT_FRAC     2
`define MNT_BIT_REQ      0
`define MNT_BIT_ACK      1
`define MNT_BIT_REFLOAD  2
`define MNT_MODE_LSB     4
`define MNT_MODE_MSB     6
`define MNT_UPD_WMASK    8'h75
`define MNT_CFG_WMASK    8'h3f
`endif

/* design/mnt_pkg.sv */
// types for the main tuning word update block
package mnt_pkg;
  typedef logic [47:0] mnt_word_t;
  typedef logic [15:0] mnt_phase_t;
  typedef logic [7:0]  mnt_byte_t;
endpackage : mnt_pkg

/* design/mnt_update.sv */
// main oscillator tuning word staging, update handshake and accumulator
`timescale 1ns/1ps
`include "mnt_defines.svh"
module mnt_update
  import mnt_pkg::*;
#(
  parameter int NPAGE = 2
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             ce_i,
  input  wire logic             wr_i,
  input  wire logic             rd_i,
  input  wire logic [11:0]      addr_i,
  input  wire logic [7:0]       wdata_i,
  output logic      [7:0]       rdata_o,
  input  wire logic             sysref_i,
  input  wire logic [NPAGE-1:0] chan_req_i,
  output logic      [NPAGE-1:0] chan_update_o,
  output logic      [NPAGE-1:0] cal_load_o,
  output logic      [NPAGE-1:0] lower_sideband_o,
  output logic      [NPAGE*16-1:0] phase_o
);
  // per-converter banks
  mnt_byte_t  cfg_r   [NPAGE];
  mnt_byte_t  upd_r   [NPAGE];
  mnt_byte_t  stage_r [NPAGE][12];  // 0..5 word, 6..7 phase, 8..11 unused
  mnt_word_t  modu_r  [NPAGE];
  mnt_word_t  dlt_r   [NPAGE];
  mnt_word_t  act_word_r [NPAGE];
  mnt_phase_t act_ph_r   [NPAGE];
  mnt_word_t  acc_r   [NPAGE];
  mnt_word_t  frac_r  [NPAGE];
  logic [NPAGE-1:0] ack_r;
  logic [NPAGE-1:0] req_q_r;
  logic [NPAGE-1:0] ref_arm_r;
  logic [NPAGE-1:0] auto_r;
  logic [NPAGE-1:0] page_r;
  logic [7:0]       rdata_r;
  logic [2:0]       ref_sync_r;

  // byte index of a tuning or phase address, 15 when not one
  function automatic logic [3:0] byte_idx(input logic [11:0] a);
    if (a >= `MNT_ADDR_FTW0 && a <= `MNT_ADDR_FTW5) byte_idx = 4'(a - `MNT_ADDR_FTW0);
    else if (a == `MNT_ADDR_PH0) byte_idx = 4'h6;
    else if (a == `MNT_ADDR_PH1) byte_idx = 4'h7;
    else byte_idx = 4'hf;
  endfunction : byte_idx

  // decode; reference pin goes through two flops, third for edge detect
  wire [3:0] widx     = byte_idx(addr_i);
  wire       wr_cfg   = wr_i && addr_i == `MNT_ADDR_CFG;
  wire       wr_upd   = wr_i && addr_i == `MNT_ADDR_UPD;
  wire       wr_page  = wr_i && addr_i == `MNT_ADDR_PAGE;
  wire       wr_byte  = wr_i && widx != 4'hf;
  wire       wr_mod   = wr_i && addr_i >= `MNT_ADDR_MOD0 && addr_i < `MNT_ADDR_MOD0 + 12'h6;
  wire       wr_dlt   = wr_i && addr_i >= `MNT_ADDR_DLT0 && addr_i < `MNT_ADDR_DLT0 + 12'h6;
  wire       ref_rise = ref_sync_r[1] && !ref_sync_r[2];
  wire [5:0] mod_sh   = {addr_i[2:0] - 3'(`MNT_ADDR_MOD0), 3'h0};
  wire [5:0] dlt_sh   = {addr_i[2:0] - 3'(`MNT_ADDR_DLT0), 3'h0};

  // read mux, reached through the selected page
  logic [7:0] rd_mux;
  int         sel;
  always_comb begin
    sel    = 0;
    for (int p = 0; p < NPAGE; p++) if (page_r[p]) sel = p;
    rd_mux = 8'h00;
    if (addr_i == `MNT_ADDR_CFG) rd_mux = cfg_r[sel];
    else if (addr_i == `MNT_ADDR_UPD) rd_mux = (upd_r[sel] & `MNT_UPD_WMASK)
                                             | {6'h00, ack_r[sel], 1'b0};
    else if (addr_i == `MNT_ADDR_PAGE) rd_mux = 8'(page_r);
    else if (widx != 4'hf) rd_mux = stage_r[sel][widx];
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ref_sync_r <= 3'h0;
      rdata_r    <= 8'h00;
      page_r     <= '1;
    end else if (ce_i) begin
      ref_sync_r <= {ref_sync_r[1:0], sysref_i};
      if (rd_i) rdata_r <= rd_mux;
      if (wr_page) page_r <= wdata_i[NPAGE-1:0];
    end
  end

  // one bank per converter; writes go to every page bit that is set
  for (genvar p = 0; p < NPAGE; p++) begin : g_bank
    wire hit      = page_r[p];
    wire req_now  = wr_upd && hit ? wdata_i[`MNT_BIT_REQ] : upd_r[p][`MNT_BIT_REQ];
    wire [2:0] md = upd_r[p][`MNT_MODE_MSB:`MNT_MODE_LSB];
    // modes 1..6 map to bytes 0..5; mode 0 and 7 never match
    wire auto_hit = hit && wr_byte && md != 3'h0 && md != 3'h7 && widx == {1'b0, md - 3'h1};
    wire sw_rise  = req_now && !req_q_r[p];
    wire ref_trig = ref_arm_r[p] && ref_rise;
    wire trig     = sw_rise || auto_r[p] || ref_trig;
    wire clr_ack  = wr_upd && hit && !wdata_i[`MNT_BIT_REQ];
    wire [47:0] frac_sum = frac_r[p] + dlt_r[p];
    wire        wrap     = frac_sum >= modu_r[p];
    always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
        cfg_r[p]      <= `MNT_CFG_RESET;
        upd_r[p]      <= `MNT_UPD_RESET;
        for (int b = 0; b < 12; b++) stage_r[p][b] <= 8'h00;
        modu_r[p]     <= '0;
        dlt_r[p]      <= '0;
        act_word_r[p] <= '0;
        act_ph_r[p]   <= '0;
        acc_r[p]      <= '0;
        frac_r[p]     <= '0;
        ack_r[p]      <= 1'b0;
        req_q_r[p]    <= 1'b0;
        ref_arm_r[p]  <= 1'b0;
        auto_r[p]     <= 1'b0;
        chan_update_o[p]    <= 1'b0;
        cal_load_o[p]       <= 1'b0;
        lower_sideband_o[p] <= 1'b0;
        phase_o[p*16 +: 16] <= '0;
      end else if (ce_i) begin
        if (wr_cfg && hit) cfg_r[p] <= wdata_i & `MNT_CFG_WMASK;
        if (wr_upd && hit) upd_r[p] <= wdata_i & `MNT_UPD_WMASK;
        if (wr_byte && hit) stage_r[p][widx] <= wdata_i;
        if (wr_mod && hit) modu_r[p][mod_sh +: 8] <= wdata_i;
        if (wr_dlt && hit) dlt_r[p][dlt_sh +: 8] <= wdata_i;
        req_q_r[p] <= req_now;
        auto_r[p]  <= auto_hit;  // request right after the byte write
        // arm on reference load bit, fire on next synchronised edge
        if (wr_upd && hit) ref_arm_r[p] <= wdata_i[`MNT_BIT_REFLOAD];
        else if (ref_trig) ref_arm_r[p] <= 1'b0;
        if (trig) begin
          act_word_r[p] <= {stage_r[p][5], stage_r[p][4], stage_r[p][3],
                            stage_r[p][2], stage_r[p][1], stage_r[p][0]};
          act_ph_r[p]   <= {stage_r[p][7], stage_r[p][6]};
        end
        // set wins over clear
        if (trig) ack_r[p] <= 1'b1;
        else if (clr_ack) ack_r[p] <= 1'b0;
        cal_load_o[p] <= trig;
        // channels take main triggers or their own
        chan_update_o[p] <= cfg_r[p][`MNT_BIT_FOLLOW] ? trig : chan_req_i[p];
        lower_sideband_o[p] <= cfg_r[p][`MNT_BIT_SIDEBAND];
        phase_o[p*16 +: 16] <= act_ph_r[p] + acc_r[p][47:32];
        // reference trigger resets phase; fraction carries one lsb
        if (ref_trig) begin
          acc_r[p]  <= '0;
          frac_r[p] <= '0;
        end else if (cfg_r[p][`MNT_BIT_FRAC] && modu_r[p] != '0) begin
          acc_r[p]  <= acc_r[p] + act_word_r[p] + {47'h0, wrap};
          frac_r[p] <= wrap ? frac_sum - modu_r[p] : frac_sum;
        end else begin
          acc_r[p]  <= acc_r[p] + act_word_r[p];
        end
      end
    end

    // checks on each bank, all on the datapath clock
    // a load trigger always leaves the ack set
    property p_ack_after_trig;
      @(posedge clk_i) disable iff (rst_i)
        ce_i && trig |=> ack_r[p];
    endproperty
    a_ack_after_trig: assert property (p_ack_after_trig)
      else $error("ack not set after load trigger");

    // mode zero and the undefined mode seven never arm an automatic load
    property p_no_auto_idle_mode;
      @(posedge clk_i) disable iff (rst_i)
        ce_i && (md == 3'h0 || md == 3'h7) |=> !auto_r[p];
    endproperty
    a_no_auto_idle_mode: assert property (p_no_auto_idle_mode)
      else $error("automatic request outside modes one to six");

    // calibration tone load pulse mirrors every trigger
    property p_cal_after_trig;
      @(posedge clk_i) disable iff (rst_i)
        ce_i |=> cal_load_o[p] == $past(trig);
    endproperty
    a_cal_after_trig: assert property (p_cal_after_trig)
      else $error("calibration load does not follow trigger");

    // following channels see main triggers only
    property p_follow_main;
      @(posedge clk_i) disable iff (rst_i)
        ce_i && cfg_r[p][`MNT_BIT_FOLLOW] |=> chan_update_o[p] == $past(trig);
    endproperty
    a_follow_main: assert property (p_follow_main)
      else $error("channel update not taken from main trigger");

    // independent channels see their own requests only
    property p_own_request;
      @(posedge clk_i) disable iff (rst_i)
        ce_i && !cfg_r[p][`MNT_BIT_FOLLOW] |=> chan_update_o[p] == $past(chan_req_i[p]);
    endproperty
    a_own_request: assert property (p_own_request)
      else $error("channel update not taken from own request");

    // sideband output tracks the config bit one cycle later
    property p_sideband_out;
      @(posedge clk_i) disable iff (rst_i)
        ce_i |=> lower_sideband_o[p] == $past(cfg_r[p][`MNT_BIT_SIDEBAND]);
    endproperty
    a_sideband_out: assert property (p_sideband_out)
      else $error("sideband output differs from select bit");

    // a reference edge is used once, then the arm drops
    property p_ref_disarm;
      @(posedge clk_i) disable iff (rst_i)
        ce_i && ref_trig && !(wr_upd && hit) |=> !ref_arm_r[p];
    endproperty
    a_ref_disarm: assert property (p_ref_disarm)
      else $error("reference load still armed after its edge");

    // running word only moves on a trigger, never on a byte write
    property p_word_held;
      @(posedge clk_i) disable iff (rst_i)
        ce_i && !trig |=> act_word_r[p] == $past(act_word_r[p]);
    endproperty
    a_word_held: assert property (p_word_held)
      else $error("tuning word changed without a trigger");
  end

  assign rdata_o = rdata_r;
endmodule : mnt_update

/* testbench/mnt_host.sv */
// host model: byte register accesses on the control port
`timescale 1ns/1ps
module mnt_host (
  input  wire logic        clk_i,
  output logic             ce_o,
  output logic             wr_o,
  output logic             rd_o,
  output logic [11:0]      addr_o,
  output logic [7:0]       wdata_o,
  input  wire logic [7:0]  rdata_i
);
  // idle bus; fraction registers never programmed, so no fraction limits apply
  initial begin
    {ce_o, wr_o, rd_o, addr_o, wdata_o} = {3'h4, 12'hfff, 8'h00};
  end
  // one-cycle write strobe, then released lines show the inverse
  task automatic wreg(input logic [11:0] a, input logic [7:0] d);
    @(negedge clk_i);
    {wr_o, addr_o, wdata_o} = {1'b1, a, d};
    @(negedge clk_i);
    {wr_o, addr_o, wdata_o} = {1'b0, ~a, ~d};
  endtask : wreg
  // clock enable, changed off the sampling edge
  task automatic hold(input logic run);
    @(negedge clk_i);
    ce_o = run;
  endtask : hold
  // read data is registered, settled one cycle after the strobe
  task automatic rreg(input logic [11:0] a, output logic [7:0] d);
    @(negedge clk_i);
    {rd_o, addr_o} = {1'b1, a};
    @(negedge clk_i);
    {rd_o, addr_o} = {1'b0, ~a};
    d = rdata_i;
  endtask : rreg
endmodule : mnt_host

/* testbench/mnt_update_test.sv */
// self-checking bench for the tuning word update block
`timescale 1ns/1ps
module mnt_update_test;
  import mnt_pkg::*;
  typedef struct {logic [11:0] a; mnt_byte_t d; mnt_byte_t e;} mnt_row_s;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        sysref = 1'b0;
  logic [1:0]  chan_req = 2'h0;
  logic        ce, wr, rd;
  logic [11:0] addr;
  mnt_byte_t   wdata, rdata, d;
  logic [1:0]  upd, cal, lsb, seen_upd, seen_cal;
  logic [31:0] phase;
  mnt_byte_t   stage [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h34, 8'h12};
  int          err_count = 0;
  int          checks = 0;
  mnt_row_s    rows [6] = '{'{12'h114, 8'ha5, 8'ha5}, '{12'h115, 8'h5a, 8'h5a},
    '{12'h116, 8'h3c, 8'h3c}, '{12'h113, 8'h60, 8'h60}, '{12'h112, 8'hff, 8'h3f},
    '{12'h200, 8'hff, 8'h00}};
  always #5 clk_i = ~clk_i;
  mnt_host u_host (.clk_i(clk_i), .ce_o(ce), .wr_o(wr), .rd_o(rd), .addr_o(addr),
    .wdata_o(wdata), .rdata_i(rdata));
  mnt_update u_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wr_i(wr), .rd_i(rd),
    .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata), .sysref_i(sysref), .chan_req_i(chan_req),
    .chan_update_o(upd), .cal_load_o(cal), .lower_sideband_o(lsb), .phase_o(phase));
  // sticky record of one-cycle pulses, so no edge is missed
  always @(posedge clk_i) {seen_upd, seen_cal} <= {seen_upd | upd, seen_cal | cal};
  task automatic clr;
    {seen_upd, seen_cal} = 4'h0;
  endtask : clr
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic final_report;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report
  task automatic do_reset;
    rst_i = 1'b1;
    repeat (16) @(negedge clk_i);
    rst_i = 1'b0;
  endtask : do_reset
  // bounded wait for a load on both pages
  task automatic wait_cal;
    for (int n = 0; seen_cal !== 2'h3; n++) begin
      if (n == 20) begin
        err_count++;
        $display("ERROR %0t: load timeout", $time);
        final_report();
      end
      @(negedge clk_i);
    end
  endtask : wait_cal
  task automatic pulse(input logic [1:0] v);
    @(negedge clk_i);
    chan_req = v;
    @(negedge clk_i);
    chan_req = 2'h0;
    repeat (3) @(negedge clk_i);
  endtask : pulse
  initial begin
    do_reset();
    foreach (rows[i]) begin
      u_host.wreg(rows[i].a, rows[i].d);
      u_host.rreg(rows[i].a, d);
      chk(d, rows[i].e);
    end
    chk({6'h0, lsb}, 8'h03);
    // reset values, then own requests ignored while following main
    do_reset();
    for (int i = 0; i < 8; i++) begin
      u_host.rreg(12'(12'h112 + i), d);
      chk(d, i == 0 ? 8'h01 : 8'h00);
    end
    clr();
    pulse(2'h3);
    chk({6'h0, seen_upd}, 8'h00);
    // clear then set the request
    u_host.wreg(12'h114, 8'h01);
    u_host.wreg(12'h113, 8'h00);
    u_host.rreg(12'h113, d);
    chk(d, 8'h00);
    clr();
    u_host.wreg(12'h113, 8'h01);
    wait_cal();
    chk({4'h0, seen_upd, seen_cal}, 8'h0f);
    u_host.rreg(12'h113, d);
    chk(d, 8'h03);
    // page 0 alone: own requests, lower sideband
    u_host.wreg(12'h008, 8'h01);
    u_host.wreg(12'h112, 8'h02);
    clr();
    pulse(2'h3);
    chk({4'h0, seen_upd, lsb}, 8'h05);
    u_host.wreg(12'h008, 8'h02);
    u_host.rreg(12'h112, d);
    chk(d, 8'h01);
    u_host.wreg(12'h008, 8'h03);
    // every automatic mode, the byte that should fire it
    for (int m = 0; m < 7; m++) begin
      u_host.wreg(12'h113, 8'(m << 4));
      clr();
      u_host.wreg(m == 0 ? 12'h114 : 12'(12'h113 + m), 8'h11);
      repeat (4) @(negedge clk_i);
      u_host.rreg(12'h113, d);
      chk({6'h0, seen_cal}, m == 0 ? 8'h00 : 8'h03);
      chk(d, 8'(m << 4) | (m == 0 ? 8'h00 : 8'h02));
    end
    // reference edge load, synchronised before it acts
    u_host.wreg(12'h113, 8'h04);
    clr();
    repeat (4) @(negedge clk_i);
    chk({6'h0, seen_cal}, 8'h00);
    sysref = 1'b1;
    @(negedge clk_i);
    chk({6'h0, seen_cal}, 8'h00);
    wait_cal();
    u_host.rreg(12'h113, d);
    chk(d, 8'h06);
    // undefined mode 7 never fires, not even on the phase bytes
    sysref = 1'b0;
    u_host.wreg(12'h113, 8'h70);
    clr();
    for (int b = 0; b < 8; b++) begin
      u_host.wreg(b < 6 ? 12'(12'h114 + b) : 12'(12'h116 + b), stage[b]);
    end
    repeat (4) @(negedge clk_i);
    chk({6'h0, seen_cal}, 8'h00);
    // reference load of word 2^32 and offset, then one phase step a cycle
    u_host.wreg(12'h113, 8'h04);
    clr();
    sysref = 1'b1;
    wait_cal();
    chk(phase[7:0], 8'h34);
    chk(phase[15:8], 8'h12);
    chk(phase[23:16], 8'h34);
    chk(phase[31:24], 8'h12);
    repeat (5) @(negedge clk_i);
    chk(phase[7:0], 8'h39);
    chk(phase[23:16], 8'h39);
    // clock enable low freezes the phase and drops writes
    u_host.hold(1'b0);
    u_host.wreg(12'h114, 8'h77);
    chk(phase[7:0], 8'h3a);
    u_host.hold(1'b1);
    u_host.rreg(12'h114, d);
    chk(d, 8'h00);
    final_report();
  end
endmodule : mnt_update_test
